// File: gex_bus_ctrl.sv
`default_nettype none
module gex_bus_ctrl (
    output var logic scl,    // Bus clock, still between frames
    output var logic sda_lo, // High pulls the data line low
    input  wire logic sda    // Resolved data line
);
    timeunit 1ns;
    timeprecision 10ps;
    localparam real Q = 31.25; // Quarter of a 125 ns bit
    initial begin
        scl = 1'b1;
        sda_lo = 1'b0;
    end
    // Data moves a quarter bit after the clock falls; only start and stop move it while clock is high
    task automatic start;
        #Q sda_lo = 1'b0;
        #Q scl = 1'b1;
        #(2*Q) sda_lo = 1'b1;
        #(2*Q) scl = 1'b0;
    endtask
    task automatic stop;
        #Q sda_lo = 1'b1;
        #Q scl = 1'b1;
        #(2*Q) sda_lo = 1'b0;
        #(4*Q);
    endtask
    task automatic xbit(input logic b, output logic r);
        #Q sda_lo = !b;
        #Q scl = 1'b1;
        #Q r = sda;
        #Q scl = 1'b0;
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], r);
        xbit(1'b1, r);
        ack = !r;
    endtask
    task automatic rd(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
        xbit(last, r);
    endtask
endmodule
`default_nettype wire

// File: gex_map.vh
`ifndef GEX_MAP_VH
`define GEX_MAP_VH
// Four-bit base of the seven-bit target address; select pins fill the low three bits
`define GEX_ADDR_BASE    4'h4
// Command values held in the register pointer
`define GEX_CMD_INPUT    2'h0
`define GEX_CMD_OUTPUT   2'h1
`define GEX_CMD_INVERT   2'h2
`define GEX_CMD_DIR      2'h3
// Register defaults after power-on
`define GEX_RST_OUTPUT   8'hFF
`define GEX_RST_INVERT   8'h00
`define GEX_RST_DIR      8'hFF
`define GEX_RST_INPUT    8'hFF
// Bit count of one byte, minus one
`define GEX_BIT_LAST     3'h7
`endif

// File: gex_port.v
`default_nettype none
`include "gex_map.vh"
module gex_port #(
    parameter W = 8
) (
    input  wire         mclk,      // System clock
    input  wire         rst_b,     // Async reset, active low
    input  wire [W-1:0] dir_cfg,   // 1 = input, 0 = output
    input  wire [W-1:0] out_val,   // Output value register
    output reg  [W-1:0] pu_on,     // Pull-up driver enable
    output reg  [W-1:0] pd_on      // Pull-down driver enable
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_pin
            always @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    pu_on[i] <= 1'b0;
                    pd_on[i] <= 1'b0;
                end else begin
                    // Input pin: both drivers off; output: exactly one on
                    pu_on[i] <= ~dir_cfg[i] & out_val[i];
                    pd_on[i] <= ~dir_cfg[i] & ~out_val[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// File: gex_sync.v
`default_nettype none
module gex_sync #(
    parameter W = 1
) (
    input  wire         mclk,    // System clock
    input  wire         rst_b,   // Async reset, active low
    input  wire [W-1:0] d_in,    // Asynchronous input
    output wire [W-1:0] q_out    // Synchronised output
);
    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= {W{1'b1}};
            s2_r <= {W{1'b1}};
        end else begin
            s1_r <= d_in;
            s2_r <= s1_r;
        end
    end

    assign q_out = s2_r;
endmodule
`default_nettype wire

// File: gex_top.v
// Behaviour
// - Input pin: both pin drivers off, high impedance.
// - Output pin: exactly one driver on, chosen by output value bit.
// - Any edge on an input-mode pin raises the interrupt.
// - Interrupt withdrawn when the pin returns to its earlier level.
// - Interrupt withdrawn when the controller reads the input port.
// - Read clear happens at the acknowledge bit after clock rise.
// - Changes after a clear are detected again and re-raise interrupt.
// - Traffic to other targets leaves interrupt state alone.
// - Output-mode pins never raise the interrupt.
// - Output-to-input switch may raise interrupt on mismatch.
// - Interrupt pin is open-drain, pull-down only.
// - Reset loads all registers and bus state defaults.
// - Bytes shift most significant bit first.
// - Data fall with clock high is START; rise is STOP.
// - Data stable while clock high; changes are conditions.
// - Eight data bits then one acknowledge bit, any byte count.
// - Addressed receiver acknowledges every byte, low through clock high.
// - Missing acknowledge ends read; device releases data line.
// - Address last bit: 1 read, 0 write.
// - Select pins all low gives target address 20h.
// - First write byte is command; 00h-03h pick registers.
// - Direction 1 is input, 0 is output.
// - Input register shows pin levels, inverted per polarity bit.
// - Pointer never auto-advances.
`default_nettype none
`include "gex_map.vh"
module gex_top #(
    parameter W = 8
) (
    input  wire         mclk,               // 100 MHz system clock
    input  wire         rst_b,              // Power-on reset, active low
    input  wire         scl_in,             // Serial clock pin
    input  wire         sda_in,             // Serial data pin level
    output reg          sda_out,            // Serial data drive value
    output reg          sda_oe,             // Serial data drive enable
    input  wire         addr_sel_bit_low,   // Address select pin 0
    input  wire         addr_sel_bit_mid,   // Address select pin 1
    input  wire         addr_sel_bit_high,  // Address select pin 2
    input  wire [W-1:0] port_in,            // Port pin levels
    output wire [W-1:0] pin_pullup_driver,  // Per-pin pull-up enable
    output wire [W-1:0] pin_pulldown_driver,// Per-pin pull-down enable
    output reg          irq_out,            // Interrupt drive value
    output reg          irq_oe              // Interrupt drive enable
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_ADDR  = 3'h1;
    localparam ST_AACK  = 3'h2;
    localparam ST_WR    = 3'h3;
    localparam ST_WACK  = 3'h4;
    localparam ST_RD    = 3'h5;
    localparam ST_RACK  = 3'h6;

    wire         scl_s;
    wire         sda_s;
    wire [2:0]   asel_s;
    wire [W-1:0] pin_s;

    gex_sync #(.W(2)) u_bus_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .d_in  ({scl_in, sda_in}),
        .q_out ({scl_s, sda_s})
    );
    gex_sync #(.W(3)) u_asel_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .d_in  ({addr_sel_bit_high, addr_sel_bit_mid, addr_sel_bit_low}),
        .q_out (asel_s)
    );
    gex_sync #(.W(W)) u_pin_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .d_in  (port_in),
        .q_out (pin_s)
    );

    reg         scl_d_r;
    reg         sda_d_r;
    reg [2:0]   state_r;
    reg [2:0]   bit_r;
    reg [7:0]   shift_r;
    reg         first_wr_r;
    reg [1:0]   ptr_r;
    reg [W-1:0] out_r;
    reg [W-1:0] inv_r;
    reg [W-1:0] dir_r;
    reg [W-1:0] snap_r;
    reg         rd_clear_r;
    reg         byte_full_r;

    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    // Conditions only while clock stays high; data edges there are not data
    wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // Input register view: raw level xor polarity bit
    wire [W-1:0] in_view = pin_s ^ inv_r;

    function [7:0] reg_sel;
        input [1:0] p;
        begin
            case (p)
                `GEX_CMD_INPUT:  reg_sel = in_view;
                `GEX_CMD_OUTPUT: reg_sel = out_r;
                `GEX_CMD_INVERT: reg_sel = inv_r;
                `GEX_CMD_DIR:    reg_sel = dir_r;
                default:         reg_sel = 8'h00;
            endcase
        end
    endfunction

    // Byte the read side will send next; pointer never moves
    wire [7:0] rd_byte = reg_sel(ptr_r);

    // Target address match on the upper seven bits of the first byte
    wire addr_hit = (shift_r[7:1] == {`GEX_ADDR_BASE, asel_s});

    // Interrupt: any input-mode pin differing from the snapshot
    wire [W-1:0] diff = (pin_s ^ snap_r) & dir_r;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Bus state machine; all registers take defaults on reset
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r    <= ST_IDLE;
            bit_r      <= 3'h0;
            shift_r    <= 8'h00;
            first_wr_r <= 1'b0;
            ptr_r      <= `GEX_CMD_INPUT;
            out_r      <= `GEX_RST_OUTPUT;
            inv_r      <= `GEX_RST_INVERT;
            dir_r      <= `GEX_RST_DIR;
            sda_out    <= 1'b0;
            sda_oe     <= 1'b0;
            rd_clear_r <= 1'b0;
            byte_full_r <= 1'b0;
        end else begin
            rd_clear_r <= 1'b0;
            if (start_c) begin
                state_r     <= ST_ADDR;
                bit_r       <= 3'h0;
                byte_full_r <= 1'b0;
                sda_oe      <= 1'b0;
            end else if (stop_c) begin
                state_r <= ST_IDLE;
                sda_oe  <= 1'b0;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    ST_ADDR, ST_WR: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_s};
                            bit_r   <= bit_r + 3'h1;
                            // Eighth rise seen; the START fall must not count
                            byte_full_r <= (bit_r == `GEX_BIT_LAST);
                        end
                        if (scl_fall) begin
                            byte_full_r <= 1'b0;
                        end
                        if (scl_fall && byte_full_r && sda_oe == 1'b0 &&
                            state_r == ST_ADDR) begin
                            if (addr_hit) begin
                                sda_out <= 1'b0;
                                sda_oe  <= 1'b1;
                                state_r <= ST_AACK;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                        if (scl_fall && byte_full_r && state_r == ST_WR) begin
                            if (first_wr_r)
                                ptr_r <= shift_r[1:0];
                            else if (ptr_r == `GEX_CMD_OUTPUT)
                                out_r <= shift_r;
                            else if (ptr_r == `GEX_CMD_INVERT)
                                inv_r <= shift_r;
                            else if (ptr_r == `GEX_CMD_DIR)
                                dir_r <= shift_r;
                            first_wr_r <= 1'b0;
                            sda_out    <= 1'b0;
                            sda_oe     <= 1'b1;
                            state_r    <= ST_WACK;
                        end
                    end
                    ST_AACK: begin
                        if (scl_fall) begin
                            bit_r <= 3'h0;
                            if (shift_r[0]) begin
                                shift_r <= {rd_byte[6:0], 1'b0};
                                sda_out <= rd_byte[7];
                                sda_oe  <= 1'b1;
                                bit_r   <= 3'h1;
                                state_r <= ST_RD;
                            end else begin
                                sda_oe     <= 1'b0;
                                first_wr_r <= 1'b1;
                                state_r    <= ST_WR;
                            end
                        end
                    end
                    ST_WACK: begin
                        if (scl_fall) begin
                            sda_oe  <= 1'b0;
                            bit_r   <= 3'h0;
                            state_r <= ST_WR;
                        end
                    end
                    ST_RD: begin
                        if (scl_fall) begin
                            if (bit_r == 3'h0) begin
                                sda_oe  <= 1'b0;  // Hand line to controller
                                state_r <= ST_RACK;
                            end else begin
                                sda_out <= shift_r[7];
                                shift_r <= {shift_r[6:0], 1'b0};
                                bit_r   <= bit_r + 3'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            // Clear at the acknowledge clock rise
                            rd_clear_r <= (ptr_r == `GEX_CMD_INPUT);
                            if (sda_s)
                                state_r <= ST_IDLE;
                        end
                        if (scl_fall) begin
                            // Same register again: no auto-advance
                            shift_r <= {rd_byte[6:0], 1'b0};
                            sda_out <= rd_byte[7];
                            sda_oe  <= 1'b1;
                            bit_r   <= 3'h1;
                            state_r <= ST_RD;
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // Snapshot of pin levels as last read; held until the next input read
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            snap_r <= `GEX_RST_INPUT;
        end else if (rd_clear_r) begin
            snap_r <= pin_s;
        end
    end

    // Open-drain: only ever pulls low
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            irq_out <= 1'b0;
            irq_oe  <= 1'b0;
        end else begin
            irq_out <= 1'b0;
            irq_oe  <= |diff & ~rd_clear_r;
        end
    end

    gex_port #(.W(W)) u_port (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .dir_cfg (dir_r),
        .out_val (out_r),
        .pu_on   (pin_pullup_driver),
        .pd_on   (pin_pulldown_driver)
    );
endmodule
`default_nettype wire

// File: gex_top_assertions.sv
`default_nettype none
module gex_top_assertions #(
    parameter W = 8
) (
    input wire logic         mclk,                // System clock
    input wire logic         rst_b,               // Async reset, low
    input wire logic         scl_in,              // Bus clock pin
    input wire logic         sda_out,             // Data drive value
    input wire logic         sda_oe,              // Data drive enable
    input wire logic [W-1:0] port_in,             // Pin levels
    input wire logic [W-1:0] pin_pullup_driver,   // Pull-up enables
    input wire logic [W-1:0] pin_pulldown_driver, // Pull-down enables
    input wire logic         irq_out,             // Interrupt value
    input wire logic         irq_oe               // Interrupt enable
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Pins with neither driver on are inputs
    wire logic [W-1:0] in_m = ~(pin_pullup_driver | pin_pulldown_driver);

    reset_dflt_a: assert property (
        $rose(rst_b) |-> !sda_oe && !irq_oe && in_m == '1)
        else $error("drive active right after reset");
    drv_excl_a: assert property (
        (pin_pullup_driver & pin_pulldown_driver) == '0)
        else $error("both pin drivers on");
    irq_od_a: assert property (!irq_out)
        else $error("interrupt line driven high");
    irq_cause_a: assert property (
        $rose(irq_oe) |-> !$past(rst_b, 8) ||
        (($past(port_in, 8) ^ port_in) & in_m) != '0 ||
        $past(pin_pullup_driver, 8) != pin_pullup_driver ||
        $past(pin_pulldown_driver, 8) != pin_pulldown_driver)
        else $error("interrupt raised without input change");
    irq_clear_a: assert property (
        $fell(irq_oe) |-> scl_in || $past(port_in, 8) != port_in)
        else $error("interrupt cleared without cause");
    sda_steady_a: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe & ~sda_out))
        else $error("data drive changed while clock high");
    drive_low_a: assert property (
        $rose(sda_oe) |-> !scl_in ##1 !scl_in)
        else $error("data drive began outside clock low");
    sda_release_a: assert property (
        $rose(sda_oe) |-> ##[1:150] !sda_oe)
        else $error("data line not released");
endmodule

bind gex_top gex_top_assertions #(.W(W)) gex_top_assertions_inst (
    .mclk(mclk), .rst_b(rst_b), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .port_in(port_in),
    .pin_pullup_driver(pin_pullup_driver),
    .pin_pulldown_driver(pin_pulldown_driver),
    .irq_out(irq_out), .irq_oe(irq_oe));
`default_nettype wire

// File: gex_top_tb.sv
`default_nettype none
`include "gex_map.vh"
module gex_top_tb;
    timeunit 1ns;
    timeprecision 10ps;
    logic       mclk, rst_b, sda_out, sda_oe, irq_oe, scl, sda_lo, ack;
    logic       irq_o;
    logic [2:0] sel;
    logic [6:0] dev;
    logic [7:0] ext, pu, pd, got;
    int         fail_count, checks_done;
    int         cyc = 0;
    // Open-drain data line with pull-up
    wire logic  sda = !(sda_oe && !sda_out) && !sda_lo;

    gex_top #(.W(8)) gex_top_inst (
        .mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_sel_bit_low(sel[0]), .addr_sel_bit_mid(sel[1]),
        .addr_sel_bit_high(sel[2]), .port_in(pu | (ext & ~pd)),
        .pin_pullup_driver(pu), .pin_pulldown_driver(pd),
        .irq_out(irq_o), .irq_oe(irq_oe));
    gex_bus_ctrl gex_bus_ctrl_inst (.scl(scl), .sda_lo(sda_lo), .sda(sda));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            end_sim();
        end
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic send(input logic [7:0] b, input logic ea);
        gex_bus_ctrl_inst.wr(b, ack);
        chk({7'h00, ack}, {7'h00, ea});
    endtask
    task automatic rd_now(input logic [7:0] e);
        gex_bus_ctrl_inst.start();
        send({dev, 1'b1}, 1'b1);
        gex_bus_ctrl_inst.rd(1'b0, got);
        chk(got, e);
        gex_bus_ctrl_inst.rd(1'b1, got);
        chk(got, e);
        gex_bus_ctrl_inst.stop();
    endtask
    task automatic rd_reg(input logic [7:0] c, e);
        gex_bus_ctrl_inst.start();
        send({dev, 1'b0}, 1'b1);
        send(c, 1'b1);
        rd_now(e);
    endtask
    task automatic wr_reg(input logic [7:0] c, d);
        gex_bus_ctrl_inst.start();
        send({dev, 1'b0}, 1'b1);
        send(c, 1'b1);
        send(d, 1'b1);
        gex_bus_ctrl_inst.stop();
    endtask
    task automatic pins(input logic [7:0] v);
        @(negedge mclk) ext = v;
        repeat (10) @(negedge mclk);
    endtask

    initial begin
        rst_b = 1'b0;
        sel = 3'h0;
        ext = 8'hFF;
        dev = 7'h20;
        fail_count = 0;
        checks_done = 0;
        repeat (16) @(negedge mclk);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        chk(pu | pd, 8'h00);
        chk({7'h00, irq_oe}, 8'h00);
        rd_now(`GEX_RST_INPUT);
        wr_reg(8'h03, 8'h0F);
        wr_reg(8'h01, 8'hA5);
        chk(pu, 8'hA0);
        chk(pd, 8'h50);
        chk({7'h00, irq_oe}, 8'h00);
        rd_reg(8'h01, 8'hA5);
        rd_reg(8'h03, 8'h0F);
        rd_reg(8'h00, 8'hAF);
        pins(8'hFE);
        chk({7'h00, irq_oe}, 8'h01);
        pins(8'hFF);
        chk({7'h00, irq_oe}, 8'h00);
        pins(8'hFE);
        gex_bus_ctrl_inst.start();
        send({7'h21, 1'b1}, 1'b0);
        gex_bus_ctrl_inst.stop();
        chk({7'h00, irq_oe}, 8'h01);
        rd_now(8'hAE);
        chk({7'h00, irq_oe}, 8'h00);
        pins(8'hFF);
        chk({7'h00, irq_oe}, 8'h01);
        rd_now(8'hAF);
        wr_reg(8'h01, 8'h0A);
        chk({pu[7:4], pd[7:4]}, 8'h0F);
        chk({7'h00, irq_oe}, 8'h00);
        wr_reg(8'h03, 8'hFF);
        repeat (10) @(negedge mclk);
        chk({7'h00, irq_oe}, 8'h01);
        chk({7'h00, irq_o}, 8'h00);
        chk(pu | pd, 8'h00);
        wr_reg(8'h02, 8'hFF);
        rd_reg(8'h00, 8'h00);
        @(negedge mclk) sel = 3'h5;
        dev = 7'h25;
        repeat (10) @(negedge mclk);
        rd_reg(8'h01, 8'h0A);
        gex_bus_ctrl_inst.start();
        send(8'h40, 1'b0);
        gex_bus_ctrl_inst.stop();
        end_sim();
    end
endmodule
`default_nettype wire
